// >>> shared/rps_map.vh
// register offsets, field positions and reset values for the receive-port status flags
// assumes it is included by bare name from the design file
// Function
// - bit 7 sticks when a past frame had unsteady row width; read clears it
// - row width steady only if every row of the frame has equal length
// - bit 6 reports row width change; read clears it
// - bit 5 sticks on link coding fault; read clears it
// - coding faults flagged only with fault counting on and limit above 1
// - bit 4 sticks on packet fifo overflow; read clears it
// - bit 3 live camera receive error summary; read does not clear it
// - bit 1 live link clock missing, also when rate below low limit
// - bit 0 reports row count change; read clears it
// - one copy per receive port; port-select register picks which copy is reached
`ifndef RPS_MAP_VH
`define RPS_MAP_VH

// ============================================================
// offsets
`define RPS_OFF_PORT_SEL      8'h4c
`define RPS_OFF_STATUS_TWO    8'h4e

// ============================================================
// field positions of rx_port_status_two
`define RPS_BIT_ROW_UNSTEADY  7
`define RPS_BIT_ROW_WIDTH_CHG 6
`define RPS_BIT_CODING_FAULT  5
`define RPS_BIT_FIFO_OVF      4
`define RPS_BIT_CAMERA_ERR    3
`define RPS_BIT_RATE_SETTLED  2
`define RPS_BIT_CLK_MISSING   1
`define RPS_BIT_ROW_COUNT_CHG 0

// ============================================================
// reset values and limits
`define RPS_RST_STATUS_TWO    8'h00
`define RPS_RST_PORT_SEL      8'h00
`define RPS_FAULT_LIMIT_MIN   3'h1

`endif

// >>> verif/rps_host_model.sv
// host side: single-byte reads and writes on the register strobes
// assumes tasks are called just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module rps_host_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	output var  logic [7:0] o_addr, o_wdata,
	output var  logic       o_wr, o_rd
);
	initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
	// port select written before any status read reaches a port
	task automatic wr(input logic [7:0] a, d);
		@(posedge i_clk) #1;
		{o_addr, o_wdata, o_wr} = {a, d, 1'b1};
		@(posedge i_clk) #1;
		{o_wdata, o_wr} = {~d, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk) #1;
		{o_addr, o_rd} = {a, 1'b1};
		@(posedge i_clk) #1;
		o_rd = 1'b0;
		d = i_rdata;
	endtask
endmodule // rps_host_model
`default_nettype wire

// >>> verif/rps_status_two_chk.sv
// checker for the receive-port status register reads
// assumes one clock, sync reset, bound to the design top
`timescale 1ns/1ps
`default_nettype none
module rps_status_two_chk #(parameter N_PORTS = 4, parameter FREQ_W = 16) (
	input wire logic                      i_clk, i_srst, i_reg_wr, i_reg_rd,
	input wire logic [7:0]                i_reg_addr, i_reg_wdata, o_reg_rdata,
	input wire logic [N_PORTS-1:0]        i_coding_fault, i_fifo_overflow,
	input wire logic [N_PORTS-1:0]        i_camera_rx_err, i_rate_settled, i_clk_absent,
	input wire logic [N_PORTS*FREQ_W-1:0] i_rate_measured,
	input wire logic [FREQ_W-1:0]         i_rate_low_limit,
	input wire logic                      i_link_fault_count_en,
	input wire logic [2:0]                i_link_fault_limit
);
	// ============================================================
	// shadow of the port select, so reads can be predicted
	logic [7:0] sel_reg;
	wire  [1:0] s = sel_reg[1:0];
	wire        rd_st = i_reg_rd && i_reg_addr == 8'h4e;
	wire        cf_on = i_coding_fault[s] && i_link_fault_count_en && i_link_fault_limit > 3'h1;
	wire        quiet = !cf_on && !i_fifo_overflow[s];
	wire [1:0]  lv2 = {i_camera_rx_err[s], i_rate_settled[s]};
	wire        miss = i_clk_absent[s] | (i_rate_measured[s*FREQ_W+:FREQ_W] < i_rate_low_limit);
	always @(posedge i_clk) begin
		if (i_srst)
			sel_reg <= 8'h00;
		else if (i_reg_wr && i_reg_addr == 8'h4c)
			sel_reg <= i_reg_wdata;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// ============================================================
	// assertions
	rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data moved without a read");
	live_bits_a: assert property (rd_st |=> o_reg_rdata[3:2] == $past(lv2))
		else $error("live bits 3:2 wrong");
	clk_miss_a: assert property (rd_st |=> o_reg_rdata[1] == $past(miss))
		else $error("clock missing bit wrong");
	sel_back_a: assert property (i_reg_rd && i_reg_addr == 8'h4c |=> o_reg_rdata == $past(sel_reg))
		else $error("port select readback wrong");
	unmapped_zero_a: assert property (i_reg_rd && i_reg_addr != 8'h4c && !rd_st |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	ovf_sticky_a: assert property (i_fifo_overflow[s] && !i_reg_wr ##1 !i_reg_wr && !i_reg_rd ##1 rd_st |=> o_reg_rdata[4])
		else $error("overflow flag lost");
	coding_on_a: assert property (cf_on && !i_reg_wr ##1 !i_reg_wr && !i_reg_rd ##1 rd_st |=> o_reg_rdata[5])
		else $error("coding fault flag lost");
	rc_clear_a: assert property (rd_st && !i_reg_wr && quiet ##1 !i_reg_wr && quiet ##1 rd_st |=> o_reg_rdata[5:4] == 2'b00)
		else $error("flags not cleared by read");
endmodule // rps_status_two_chk
bind rps_status_two rps_status_two_chk #(.N_PORTS(N_PORTS), .FREQ_W(FREQ_W)) i_chk (
	.i_clk(i_clk), .i_srst(i_srst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
	.i_coding_fault(i_coding_fault), .i_fifo_overflow(i_fifo_overflow),
	.i_camera_rx_err(i_camera_rx_err), .i_rate_settled(i_rate_settled),
	.i_clk_absent(i_clk_absent), .i_rate_measured(i_rate_measured),
	.i_rate_low_limit(i_rate_low_limit), .i_link_fault_count_en(i_link_fault_count_en),
	.i_link_fault_limit(i_link_fault_limit));
`default_nettype wire

// >>> verif/test_rps_status_two.sv
// self-checking bench for the receive-port status flags
// assumes host model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_rps_status_two;
	logic        i_clk = 0, i_srst = 1, en = 1;
	logic [3:0]  row_end = 0, frame_end = 0, cf = 0, ovf = 0, cam = 0, settled = 0, absent = 0;
	logic [63:0] row_len = 0, meas = 0;
	logic [15:0] lim = 0;
	logic [2:0]  flim = 3'h2;
	logic [7:0]  v, w;
	logic [16:0] seq [8] = '{17'ha, 17'ha, 17'h10000, 17'ha, 17'hc, 17'h10000, 17'h14, 17'h10000};
	wire  [7:0]  addr, wdata, rdata;
	wire         i_wr, i_rd;
	int          n_fail = 0, n_checks = 0, seed, p;
	always #12.5 i_clk = ~i_clk;
	rps_status_two i_rps_status_two (.i_clk(i_clk), .i_srst(i_srst), .i_reg_addr(addr),
		.i_reg_wr(i_wr), .i_reg_wdata(wdata), .i_reg_rd(i_rd), .o_reg_rdata(rdata),
		.i_row_end(row_end), .i_row_len(row_len), .i_frame_end(frame_end), .i_coding_fault(cf),
		.i_fifo_overflow(ovf), .i_camera_rx_err(cam), .i_rate_settled(settled),
		.i_clk_absent(absent), .i_rate_measured(meas), .i_rate_low_limit(lim),
		.i_link_fault_count_en(en), .i_link_fault_limit(flim));
	rps_host_model host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(i_wr), .o_rd(i_rd));
	// ============================================================
	// helpers
	function automatic logic [7:0] live(int q);
		return {4'h0, cam[q], settled[q], absent[q] | (meas[q*16+:16] < lim), 1'b0};
	endfunction
	task automatic chk(input string n, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdchk(input string n, input logic [7:0] a, e);
		host.rd(a, v);
		chk(n, e, v);
	endtask
	task automatic ev(input logic [3:0] r, f, c, o, input logic [15:0] l);
		@(posedge i_clk) #1;
		{row_end, frame_end, cf, ovf} = {r, f, c, o};
		row_len[15:0] = l;
		@(posedge i_clk) #1;
		{row_end, frame_end, cf, ovf} = 16'h0;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ============================================================
	// scenarios
	initial begin
		seed = $urandom(41165);
		repeat (10) @(posedge i_clk);
		#1 i_srst = 0;
		for (p = 0; p < 4; p++) begin
			{cam, settled, absent} = 12'($urandom);
			meas = {$urandom, $urandom};
			lim = 16'($urandom);
			w = {6'($urandom), p[1:0]};
			host.wr(8'h4c, w);
			rdchk("port select", 8'h4c, w);
			rdchk("status idle", 8'h4e, live(p));
			ev(0, 0, 4'h1 << p, 4'h1 << p, 0);
			rdchk("status events", 8'h4e, 8'h30 | live(p));
			rdchk("status cleared", 8'h4e, live(p));
		end
		flim = 3'h1;
		ev(0, 0, 4'h8, 0, 0);
		rdchk("fault gated", 8'h4e, live(3));
		{flim, en} = {3'h2, 1'b0};
		ev(0, 0, 4'h8, 0, 0);
		rdchk("fault count off", 8'h4e, live(3));
		en = 1;
		host.wr(8'h4e, 8'hff);
		rdchk("write ignored", 8'h4e, live(3));
		rdchk("unmapped", 8'h4f, 8'h00);
		fork host.rd(8'h4e, v); ev(0, 0, 0, 4'h8, 0); join
		rdchk("same cycle", 8'h4e, 8'h10 | live(3));
		host.wr(8'h4c, 8'h00);
		foreach (seq[i]) begin
			ev(!seq[i][16], seq[i][16], 0, 0, seq[i][15:0]);
			if (i == 5) rdchk("row width unsteady", 8'h4e, 8'h80 | live(0));
		end
		rdchk("row width and count", 8'h4e, 8'h41 | live(0));
		host.wr(8'h4c, 8'h01);
		ev(0, 0, 0, 4'h3, 0);
		i_srst = 1;
		repeat (2) @(posedge i_clk);
		#1 i_srst = 0;
		rdchk("select after reset", 8'h4c, 8'h00);
		rdchk("status after reset", 8'h4e, live(0));
		tally_and_finish();
	end
	initial begin
		#100us;
		n_fail++;
		tally_and_finish();
	end
endmodule // test_rps_status_two
`default_nettype wire

// >>> verilog/rps_status_two.v
// per-receive-port status flags with clear-on-read and port-select register
// assumes a serial control slave presents byte reads/writes as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "rps_map.vh"

module rps_status_two #(
	parameter N_PORTS = 4,
	parameter SEL_W   = 2,
	parameter LEN_W   = 16,
	parameter CNT_W   = 16,
	parameter FREQ_W  = 16
) (
	// clock and reset
	input  wire                      i_clk,
	input  wire                      i_srst,
	// register port
	input  wire [7:0]                i_reg_addr,
	input  wire                      i_reg_wr,
	input  wire [7:0]                i_reg_wdata,
	input  wire                      i_reg_rd,
	output reg  [7:0]                o_reg_rdata,
	// video timing per port
	input  wire [N_PORTS-1:0]        i_row_end,
	input  wire [N_PORTS*LEN_W-1:0]  i_row_len,
	input  wire [N_PORTS-1:0]        i_frame_end,
	// link events per port
	input  wire [N_PORTS-1:0]        i_coding_fault,
	input  wire [N_PORTS-1:0]        i_fifo_overflow,
	input  wire [N_PORTS-1:0]        i_camera_rx_err,
	input  wire [N_PORTS-1:0]        i_rate_settled,
	input  wire [N_PORTS-1:0]        i_clk_absent,
	input  wire [N_PORTS*FREQ_W-1:0] i_rate_measured,
	// shared configuration
	input  wire [FREQ_W-1:0]         i_rate_low_limit,
	input  wire                      i_link_fault_count_en,
	input  wire [2:0]                i_link_fault_limit
);

	// ============================================================
	// port select and read strobes
	reg  [7:0]           port_sel_reg;
	wire [SEL_W-1:0]     rd_port;
	wire                 rd_status;
	wire                 coding_ok;
	wire [N_PORTS*8-1:0] stat_bus;

	assign rd_port   = port_sel_reg[SEL_W-1:0];
	assign rd_status = i_reg_rd && (i_reg_addr == `RPS_OFF_STATUS_TWO);
	// without counting, lock loss masks the fault before it can be seen
	assign coding_ok = i_link_fault_count_en
		&& (i_link_fault_limit > `RPS_FAULT_LIMIT_MIN);

	always @(posedge i_clk) begin
		if (i_srst) begin
			port_sel_reg <= `RPS_RST_PORT_SEL;
		end else if (i_reg_wr && (i_reg_addr == `RPS_OFF_PORT_SEL)) begin
			port_sel_reg <= i_reg_wdata;
		end
	end

	// ============================================================
	// per-port tracking
	genvar p;
	generate
		for (p = 0; p < N_PORTS; p = p + 1) begin : g_port
			reg  [LEN_W-1:0] first_len_reg;
			reg  [LEN_W-1:0] prev_len_reg;
			reg  [CNT_W-1:0] row_cnt_reg;
			reg  [CNT_W-1:0] prev_cnt_reg;
			reg              have_row_reg;
			reg              have_frame_reg;
			reg              uneven_reg;
			reg              unsteady_reg;
			reg              width_chg_reg;
			reg              fault_reg;
			reg              ovf_reg;
			reg              count_chg_reg;
			reg              unsteady_next;
			reg              width_chg_next;
			reg              fault_next;
			reg              ovf_next;
			reg              count_chg_next;
			wire [LEN_W-1:0] len;
			wire             clr;
			wire             uneven_now;
			wire             ev_unsteady;
			wire             ev_width;
			wire             ev_count;
			wire             ev_fault;
			wire             missing;

			assign len = i_row_len[p*LEN_W +: LEN_W];
			assign clr = rd_status && (rd_port == p);
			// any row unlike the first of its frame spoils the frame
			assign uneven_now = i_row_end[p] && have_row_reg
				&& (len != first_len_reg);
			assign ev_unsteady = i_frame_end[p] && (uneven_reg || uneven_now);
			assign ev_width = i_frame_end[p] && have_frame_reg && have_row_reg
				&& (first_len_reg != prev_len_reg);
			assign ev_count = i_frame_end[p] && have_frame_reg
				&& (row_cnt_reg != prev_cnt_reg);
			assign ev_fault = i_coding_fault[p] && coding_ok;
			assign missing = i_clk_absent[p]
				|| (i_rate_measured[p*FREQ_W +: FREQ_W] < i_rate_low_limit);

			always @(posedge i_clk) begin
				if (i_srst) begin
					first_len_reg  <= {LEN_W{1'b0}};
					prev_len_reg   <= {LEN_W{1'b0}};
					row_cnt_reg    <= {CNT_W{1'b0}};
					prev_cnt_reg   <= {CNT_W{1'b0}};
					have_row_reg   <= 1'b0;
					have_frame_reg <= 1'b0;
					uneven_reg     <= 1'b0;
				end else if (i_frame_end[p]) begin
					// a row end in the frame-end cycle joins neither frame's count
					prev_len_reg   <= first_len_reg;
					prev_cnt_reg   <= row_cnt_reg;
					have_frame_reg <= 1'b1;
					have_row_reg   <= 1'b0;
					uneven_reg     <= 1'b0;
					row_cnt_reg    <= {CNT_W{1'b0}};
				end else if (i_row_end[p]) begin
					if (!have_row_reg) begin
						first_len_reg <= len;
					end
					have_row_reg <= 1'b1;
					uneven_reg   <= uneven_reg || uneven_now;
					row_cnt_reg  <= row_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end

			// clearing read first, events after it, so set wins and no event is lost
			always @* begin
				unsteady_next  = unsteady_reg;
				width_chg_next = width_chg_reg;
				fault_next     = fault_reg;
				ovf_next       = ovf_reg;
				count_chg_next = count_chg_reg;
				if (clr) begin
					unsteady_next  = 1'b0;
					width_chg_next = 1'b0;
					fault_next     = 1'b0;
					ovf_next       = 1'b0;
					count_chg_next = 1'b0;
				end
				if (ev_unsteady) begin
					unsteady_next = 1'b1;
				end
				if (ev_width) begin
					width_chg_next = 1'b1;
				end
				if (ev_fault) begin
					fault_next = 1'b1;
				end
				if (i_fifo_overflow[p]) begin
					ovf_next = 1'b1;
				end
				if (ev_count) begin
					count_chg_next = 1'b1;
				end
			end

			always @(posedge i_clk) begin
				if (i_srst) begin
					unsteady_reg  <= 1'b0;
					width_chg_reg <= 1'b0;
					fault_reg     <= 1'b0;
					ovf_reg       <= 1'b0;
					count_chg_reg <= 1'b0;
				end else begin
					unsteady_reg  <= unsteady_next;
					width_chg_reg <= width_chg_next;
					fault_reg     <= fault_next;
					ovf_reg       <= ovf_next;
					count_chg_reg <= count_chg_next;
				end
			end

			assign stat_bus[p*8 + `RPS_BIT_ROW_UNSTEADY]  = unsteady_reg;
			assign stat_bus[p*8 + `RPS_BIT_ROW_WIDTH_CHG] = width_chg_reg;
			assign stat_bus[p*8 + `RPS_BIT_CODING_FAULT]  = fault_reg;
			assign stat_bus[p*8 + `RPS_BIT_FIFO_OVF]      = ovf_reg;
			assign stat_bus[p*8 + `RPS_BIT_CAMERA_ERR]    = i_camera_rx_err[p];
			assign stat_bus[p*8 + `RPS_BIT_RATE_SETTLED]  = i_rate_settled[p];
			assign stat_bus[p*8 + `RPS_BIT_CLK_MISSING]   = missing;
			assign stat_bus[p*8 + `RPS_BIT_ROW_COUNT_CHG] = count_chg_reg;
		end
	endgenerate

	// ============================================================
	// read data, registered; the low SEL_W bits of port select pick the port, and a pick at or beyond N_PORTS reads zero
	reg [7:0] rdata_next;

	always @* begin
		rdata_next = 8'h00;
		case (i_reg_addr)
			`RPS_OFF_PORT_SEL: begin
				rdata_next = port_sel_reg;
			end
			`RPS_OFF_STATUS_TWO: begin
				if (rd_port < N_PORTS) begin
					rdata_next = stat_bus[rd_port*8 +: 8];
				end
			end
			default: begin
				rdata_next = 8'h00;
			end
		endcase
	end

	always @(posedge i_clk) begin
		if (i_srst) begin
			o_reg_rdata <= `RPS_RST_STATUS_TWO;
		end else if (i_reg_rd) begin
			o_reg_rdata <= rdata_next;
		end
	end

endmodule // rps_status_two

`default_nettype wire
